// ---- inc/ioxp_pkg.sv ----
// Package: constants and types for the two-port I/O expander register block
package ioxp_pkg;
  localparam logic [3:0] IOXP_ADDR_BASE   = 4'h4;  // Fixed upper address bits 0100
  localparam logic [2:0] IOXP_REG_IN0     = 3'h0;
  localparam logic [2:0] IOXP_REG_IN1     = 3'h1;
  localparam logic [2:0] IOXP_REG_OUT0    = 3'h2;
  localparam logic [2:0] IOXP_REG_OUT1    = 3'h3;
  localparam logic [2:0] IOXP_REG_INV0    = 3'h4;
  localparam logic [2:0] IOXP_REG_INV1    = 3'h5;
  localparam logic [2:0] IOXP_REG_DIR0    = 3'h6;
  localparam logic [2:0] IOXP_REG_DIR1    = 3'h7;
  localparam int         IOXP_SEL_LSB     = 0;     // Register select field position
  localparam int         IOXP_SEL_W       = 3;
  localparam logic [7:0] IOXP_OUT_RST     = 8'hFF;
  localparam logic [7:0] IOXP_INV_RST     = 8'h00;
  localparam logic [7:0] IOXP_DIR_RST     = 8'hFF;
  localparam logic [7:0] IOXP_SEL_RST     = 8'h00;
  localparam int         IOXP_SYNC_STAGES = 3;

  typedef struct packed {
    logic [7:0] p1;
    logic [7:0] p0;
  } ioxp_pair_type;

  typedef struct packed {
    ioxp_pair_type drive;
    ioxp_pair_type invert;
    ioxp_pair_type direction;
  } ioxp_regs_type;
endpackage

// ---- rtl/ioxp_regs.sv ----
// Two-port I/O expander: bus slave on serial clock/data pins plus port register file
module ioxp_regs #(
  parameter int PORT_W = 8                           // Pins per port
) (
  input  wire logic              core_clk,           // 40 MHz core clock
  input  wire logic              sys_rst,            // Asynchronous reset, active high
  input  wire logic              scl_in,             // Serial clock pin level
  input  wire logic              sda_in,             // Serial data pin level
  output logic                   sda_oe,             // High while pulling data low
  output logic                   sda_out,            // Data drive value, always low
  input  wire logic              addr_select_hi_pin, // Address strap bit 2
  input  wire logic              addr_select_mid_pin,// Address strap bit 1
  input  wire logic              addr_select_lo_pin, // Address strap bit 0
  input  wire logic [PORT_W-1:0] first_port_pins_in,  // Port 0 pin levels
  output logic      [PORT_W-1:0] first_port_pins_out, // Port 0 drive values
  output logic      [PORT_W-1:0] first_port_pins_oe,  // Port 0 drive enables
  input  wire logic [PORT_W-1:0] second_port_pins_in, // Port 1 pin levels
  output logic      [PORT_W-1:0] second_port_pins_out,// Port 1 drive values
  output logic      [PORT_W-1:0] second_port_pins_oe  // Port 1 drive enables
);
  typedef enum logic [2:0] {
    IOXP_IDLE, IOXP_ADDR, IOXP_ACK, IOXP_WDATA, IOXP_RDATA, IOXP_RACK, IOXP_SKIP
  } ioxp_state_type;

  localparam int NS = ioxp_pkg::IOXP_SYNC_STAGES;

  // Three-stage synchronisers; a change counts once stages two and three agree
  logic [NS-1:0] scl_sync_ff;
  logic [NS-1:0] sda_sync_ff;
  logic [PORT_W-1:0] p0_s1_ff, p0_s2_ff, p0_s3_ff;
  logic [PORT_W-1:0] p1_s1_ff, p1_s2_ff, p1_s3_ff;
  logic          scl_ff, sda_ff;
  logic [PORT_W-1:0] p0_lvl_ff, p1_lvl_ff;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_sync_ff <= '1;
      sda_sync_ff <= '1;
      scl_ff      <= 1'b1;
      sda_ff      <= 1'b1;
      p0_s1_ff    <= '0;
      p0_s2_ff    <= '0;
      p0_s3_ff    <= '0;
      p1_s1_ff    <= '0;
      p1_s2_ff    <= '0;
      p1_s3_ff    <= '0;
      p0_lvl_ff   <= '0;
      p1_lvl_ff   <= '0;
    end else begin
      scl_sync_ff <= {scl_sync_ff[NS-2:0], scl_in};
      sda_sync_ff <= {sda_sync_ff[NS-2:0], sda_in};
      if (scl_sync_ff[1] == scl_sync_ff[2]) scl_ff <= scl_sync_ff[2];
      if (sda_sync_ff[1] == sda_sync_ff[2]) sda_ff <= sda_sync_ff[2];
      p0_s1_ff    <= first_port_pins_in;
      p0_s2_ff    <= p0_s1_ff;
      p0_s3_ff    <= p0_s2_ff;
      p1_s1_ff    <= second_port_pins_in;
      p1_s2_ff    <= p1_s1_ff;
      p1_s3_ff    <= p1_s2_ff;
      // Agreeing stages pass the new level, disagreeing ones hold the old
      p0_lvl_ff   <= (p0_s3_ff & ~(p0_s2_ff ^ p0_s3_ff)) | (p0_lvl_ff & (p0_s2_ff ^ p0_s3_ff));
      p1_lvl_ff   <= (p1_s3_ff & ~(p1_s2_ff ^ p1_s3_ff)) | (p1_lvl_ff & (p1_s2_ff ^ p1_s3_ff));
    end
  end

  // Bus events, judged on filtered levels one cycle apart
  logic scl_d_ff, sda_d_ff;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= scl_ff;
      sda_d_ff <= sda_ff;
    end
  end

  wire scl_rise  = scl_ff & ~scl_d_ff;
  wire scl_fall  = ~scl_ff & scl_d_ff;
  wire start_det = scl_ff & scl_d_ff & sda_d_ff & ~sda_ff;
  wire stop_det  = scl_ff & scl_d_ff & ~sda_d_ff & sda_ff;

  // Register file and transfer state
  ioxp_pkg::ioxp_regs_type regs_ff;
  logic [7:0]     sel_ff;
  ioxp_state_type state_ff, nxt_state;
  logic [7:0]     shift_ff, nxt_shift;
  logic [3:0]     bitcnt_ff, nxt_bitcnt;
  logic           cmd_phase_ff, nxt_cmd_phase;
  logic           is_read_ff, nxt_is_read;
  logic [2:0]     ptr_ff, nxt_ptr;
  logic           drive_low_ff, nxt_drive_low;
  // Marks the acknowledge of the address byte, which must neither store a command nor data
  logic           adr_ack_ff, nxt_adr_ack;

  wire [6:0] own_addr = {ioxp_pkg::IOXP_ADDR_BASE, addr_select_hi_pin,
                         addr_select_mid_pin, addr_select_lo_pin};
  wire [2:0] cmd_sel  = shift_ff[ioxp_pkg::IOXP_SEL_LSB +: ioxp_pkg::IOXP_SEL_W];
  wire [7:0] in0_view = p0_lvl_ff ^ regs_ff.invert.p0;
  wire [7:0] in1_view = p1_lvl_ff ^ regs_ff.invert.p1;

  function automatic logic [7:0] read_mux(input logic [2:0] sel, input logic [7:0] i0,
                                          input logic [7:0] i1,
                                          input ioxp_pkg::ioxp_regs_type r);
    case (sel)
      ioxp_pkg::IOXP_REG_IN0:  read_mux = i0;
      ioxp_pkg::IOXP_REG_IN1:  read_mux = i1;
      ioxp_pkg::IOXP_REG_OUT0: read_mux = r.drive.p0;
      ioxp_pkg::IOXP_REG_OUT1: read_mux = r.drive.p1;
      ioxp_pkg::IOXP_REG_INV0: read_mux = r.invert.p0;
      ioxp_pkg::IOXP_REG_INV1: read_mux = r.invert.p1;
      ioxp_pkg::IOXP_REG_DIR0: read_mux = r.direction.p0;
      default:                 read_mux = r.direction.p1;
    endcase
  endfunction

  // Other register of the same pair
  function automatic logic [2:0] pair_mate(input logic [2:0] sel);
    pair_mate = {sel[2:1], ~sel[0]};
  endfunction

  wire       byte_done = (bitcnt_ff == 4'h7) & scl_rise;
  wire [7:0] rd_byte   = read_mux(ptr_ff, in0_view, in1_view, regs_ff);
  wire       wr_commit = (state_ff == IOXP_ACK) & scl_rise & ~cmd_phase_ff & ~is_read_ff
                         & ~adr_ack_ff & (bitcnt_ff == 4'h8);

  always_comb begin
    nxt_state     = state_ff;
    nxt_shift     = shift_ff;
    nxt_bitcnt    = bitcnt_ff;
    nxt_cmd_phase = cmd_phase_ff;
    nxt_is_read   = is_read_ff;
    nxt_ptr       = ptr_ff;
    nxt_drive_low = drive_low_ff;
    nxt_adr_ack   = adr_ack_ff;
    if (stop_det) begin
      nxt_state     = IOXP_IDLE;
      nxt_drive_low = 1'b0;
      nxt_adr_ack   = 1'b0;
    end else if (start_det) begin
      nxt_state     = IOXP_ADDR;
      nxt_adr_ack   = 1'b0;
      nxt_bitcnt    = 4'h0;
      nxt_drive_low = 1'b0;
      nxt_ptr       = sel_ff[2:0];
    end else begin
      case (state_ff)
        IOXP_IDLE, IOXP_SKIP: nxt_drive_low = 1'b0;
        IOXP_ADDR, IOXP_WDATA: begin
          if (scl_rise) begin
            nxt_shift  = {shift_ff[6:0], sda_ff};
            nxt_bitcnt = bitcnt_ff + 4'h1;
          end
          if (scl_fall && bitcnt_ff == 4'h8) begin
            if (state_ff == IOXP_ADDR) begin
              if (shift_ff[7:1] == own_addr) begin
                nxt_is_read   = shift_ff[0];
                nxt_cmd_phase = ~shift_ff[0];
                nxt_drive_low = 1'b1;
                nxt_adr_ack   = 1'b1;
                nxt_state     = IOXP_ACK;
              end else begin
                nxt_state = IOXP_SKIP;
              end
            end else begin
              nxt_drive_low = 1'b1;
              nxt_state     = IOXP_ACK;
            end
          end
        end
        IOXP_ACK: begin
          if (scl_rise && !adr_ack_ff) nxt_cmd_phase = 1'b0;
          if (scl_fall) begin
            nxt_bitcnt  = 4'h0;
            nxt_adr_ack = 1'b0;
            if (is_read_ff) begin
              nxt_shift     = rd_byte;
              nxt_drive_low = ~rd_byte[7];
              nxt_state     = IOXP_RDATA;
            end else begin
              nxt_drive_low = 1'b0;
              nxt_state     = IOXP_WDATA;
            end
          end
        end
        IOXP_RDATA: begin
          if (scl_rise) nxt_bitcnt = bitcnt_ff + 4'h1;
          if (scl_fall) begin
            if (bitcnt_ff == 4'h8) begin
              nxt_drive_low = 1'b0;
              nxt_state     = IOXP_RACK;
            end else begin
              nxt_shift     = {shift_ff[6:0], 1'b0};
              nxt_drive_low = ~shift_ff[6];
            end
          end
        end
        IOXP_RACK: begin
          if (scl_rise) begin
            nxt_ptr = pair_mate(ptr_ff);
            // Missing acknowledge releases the line until the next start or stop
            if (sda_ff) nxt_state = IOXP_SKIP;
          end
          if (scl_fall) begin
            nxt_bitcnt    = 4'h0;
            nxt_shift     = read_mux(ptr_ff, in0_view, in1_view, regs_ff);
            nxt_drive_low = ~nxt_shift[7];
            nxt_state     = IOXP_RDATA;
          end
        end
        default: nxt_state = IOXP_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff     <= IOXP_IDLE;
      shift_ff     <= 8'h00;
      bitcnt_ff    <= 4'h0;
      cmd_phase_ff <= 1'b0;
      is_read_ff   <= 1'b0;
      ptr_ff       <= 3'h0;
      drive_low_ff <= 1'b0;
      adr_ack_ff   <= 1'b0;
    end else begin
      adr_ack_ff   <= nxt_adr_ack;
      state_ff     <= nxt_state;
      shift_ff     <= nxt_shift;
      bitcnt_ff    <= nxt_bitcnt;
      cmd_phase_ff <= nxt_cmd_phase;
      is_read_ff   <= nxt_is_read;
      ptr_ff       <= nxt_ptr;
      drive_low_ff <= nxt_drive_low;
    end
  end

  // Writes land on the acknowledge clock rise; bursts alternate within the pair
  wire cmd_take  = (state_ff == IOXP_ACK) & scl_rise & cmd_phase_ff & ~is_read_ff
                   & ~adr_ack_ff;
  wire data_take = wr_commit;
  logic [2:0] wptr_ff;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      regs_ff.drive     <= {ioxp_pkg::IOXP_OUT_RST, ioxp_pkg::IOXP_OUT_RST};
      regs_ff.invert    <= {ioxp_pkg::IOXP_INV_RST, ioxp_pkg::IOXP_INV_RST};
      regs_ff.direction <= {ioxp_pkg::IOXP_DIR_RST, ioxp_pkg::IOXP_DIR_RST};
      sel_ff            <= ioxp_pkg::IOXP_SEL_RST;
      wptr_ff           <= 3'h0;
    end else if (cmd_take) begin
      sel_ff  <= shift_ff;
      wptr_ff <= cmd_sel;
    end else if (data_take) begin
      wptr_ff <= pair_mate(wptr_ff);
      case (wptr_ff)
        ioxp_pkg::IOXP_REG_OUT0: regs_ff.drive.p0     <= shift_ff;
        ioxp_pkg::IOXP_REG_OUT1: regs_ff.drive.p1     <= shift_ff;
        ioxp_pkg::IOXP_REG_INV0: regs_ff.invert.p0    <= shift_ff;
        ioxp_pkg::IOXP_REG_INV1: regs_ff.invert.p1    <= shift_ff;
        ioxp_pkg::IOXP_REG_DIR0: regs_ff.direction.p0 <= shift_ff;
        ioxp_pkg::IOXP_REG_DIR1: regs_ff.direction.p1 <= shift_ff;
        default: ;  // Input registers take no write
      endcase
    end
  end

  assign sda_out              = 1'b0;
  assign sda_oe               = drive_low_ff;
  assign first_port_pins_out  = regs_ff.drive.p0;
  assign second_port_pins_out = regs_ff.drive.p1;
  assign first_port_pins_oe   = ~regs_ff.direction.p0;
  assign second_port_pins_oe  = ~regs_ff.direction.p1;
endmodule

// ---- dv/ioxp_regs_monitor.sv ----
// Checker for the expander's bus pins and port pins
module ioxp_regs_monitor #(
  parameter int PORT_W = 8                           // Pins per port
) (
  input wire logic              core_clk,             // Core clock
  input wire logic              sys_rst,              // Reset, active high
  input wire logic              scl_in,               // Serial clock level
  input wire logic              sda_in,               // Serial data level
  input wire logic              sda_oe,               // Device pulls data low
  input wire logic              sda_out,              // Data drive value
  input wire logic [PORT_W-1:0] first_port_pins_out,  // Port 0 drive values
  input wire logic [PORT_W-1:0] first_port_pins_oe,   // Port 0 drive enables
  input wire logic [PORT_W-1:0] second_port_pins_out, // Port 1 drive values
  input wire logic [PORT_W-1:0] second_port_pins_oe   // Port 1 drive enables
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_rst_all_inputs:
    assert property ($fell(sys_rst) |-> {first_port_pins_oe, second_port_pins_oe} == '0)
    else $error("pins driven after reset");
  a_rst_out_ones:
    assert property ($fell(sys_rst) |-> {first_port_pins_out, second_port_pins_out} == '1)
    else $error("drive values not all ones after reset");
  a_pins_at_ack:
    assert property ($changed({first_port_pins_out, first_port_pins_oe, second_port_pins_out,
                               second_port_pins_oe}) |-> scl_in)
    else $error("port pins changed outside the acknowledge clock");
  a_release_clk_low:
    assert property ($fell(sda_oe) |-> !scl_in)
    else $error("data released while clock high");
  a_pull_clk_low:
    assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in, 3))
    else $error("data pulled too soon after clock fall");
  a_pull_stands:
    assert property ($rose(sda_oe) |-> sda_oe [*8])
    else $error("data pull too short");
  a_open_drain:
    assert property (sda_out == 1'b0)
    else $error("data driven high");
  a_quiet_after_stop:
    assert property (scl_in && $rose(sda_in) |=> !sda_oe [*4])
    else $error("device pulls data after stop");
endmodule
bind ioxp_regs ioxp_regs_monitor #(.PORT_W(PORT_W)) i_ioxp_regs_monitor (.core_clk, .sys_rst,
  .scl_in, .sda_in, .sda_oe, .sda_out, .first_port_pins_out, .first_port_pins_oe,
  .second_port_pins_out, .second_port_pins_oe);

// ---- dv/ioxp_bus_master.sv ----
// Bus master model: start, stop and byte transfers on the open-drain pair
module ioxp_bus_master (
  input  wire logic core_clk, // Paces the bus
  input  wire logic dev_pull, // Device pulls data low
  output logic      scl,      // Serial clock, idles high
  output wire logic sda       // Resolved data wire
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 12; // Stays above the two-cycle floor of the filter
  logic m_low = 1'b0;
  initial scl = 1'b1;
  assign sda = ~(dev_pull | m_low); // Pull-up wins when nobody drives
  task automatic hw(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic bit_io(input logic b, output logic r);
    m_low = ~b;
    hw(HALF);
    scl = 1'b1;
    hw(HALF / 2);
    r = sda;
    hw(HALF / 2);
    scl = 1'b0;
  endtask
  task automatic xbyte(input logic [7:0] d, input logic a, output logic [7:0] r, output logic k);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
    bit_io(a, k);
  endtask
  task automatic start();
    m_low = 1'b0;
    hw(HALF);
    m_low = 1'b1;
    hw(HALF);
    scl = 1'b0;
  endtask
  task automatic stop(); // Ends the transfer at any point
    m_low = 1'b1;
    hw(HALF);
    scl = 1'b1;
    hw(HALF);
    m_low = 1'b0;
    hw(HALF);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] c, d0, d1, input int n,
                    output logic nak);
    logic [7:0] r;
    logic       k;
    start();
    xbyte({a, 1'b0}, 1'b1, r, nak);
    if (!nak) xbyte(c, 1'b1, r, k);
    if (!nak && n > 1) xbyte(d0, 1'b1, r, k);
    if (!nak && n > 2) xbyte(d1, 1'b1, r, k);
    stop();
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d0, d1, output logic nak);
    logic k;
    start();
    xbyte({a, 1'b1}, 1'b1, d0, nak);
    if (!nak) xbyte(8'hFF, 1'b0, d0, k);
    if (!nak) xbyte(8'hFF, 1'b1, d1, k);
    stop();
  endtask
endmodule

// ---- dv/test_ioxp_regs.sv ----
// Testbench: register accesses over the serial bus against the expander
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin bad_count++; \
  $display("BAD %0t: got %0h expected %0h", $time, got, exp); end end
module test_ioxp_regs;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [6:0] ADR = 7'h25;
  logic       core_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic [2:0] strap = 3'h5;
  logic [7:0] ext0 = 8'h00;
  logic [7:0] ext1 = 8'hFF;
  logic [7:0] p0_out, p0_oe, p1_out, p1_oe;
  logic       sda_oe;
  wire logic  scl, sda;
  int         bad_count = 0;
  int         checks_done = 0;
  initial forever #12.5 core_clk = ~core_clk;
  ioxp_bus_master i_ioxp_bus_master (.core_clk(core_clk), .dev_pull(sda_oe), .scl(scl), .sda(sda));
  ioxp_regs #(.PORT_W(8)) i_ioxp_regs (.core_clk(core_clk), .sys_rst(sys_rst), .scl_in(scl),
    .sda_in(sda), .sda_oe(sda_oe), .sda_out(), .addr_select_hi_pin(strap[2]),
    .addr_select_mid_pin(strap[1]), .addr_select_lo_pin(strap[0]),
    .first_port_pins_in((p0_oe & p0_out) | (~p0_oe & ext0)), .first_port_pins_out(p0_out),
    .first_port_pins_oe(p0_oe), .second_port_pins_in((p1_oe & p1_out) | (~p1_oe & ext1)),
    .second_port_pins_out(p1_out), .second_port_pins_oe(p1_oe));
  task automatic stop_test();
    $display("Checks done %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wreg(input logic [7:0] c, d0, d1, input int n);
    logic k;
    i_ioxp_bus_master.wr(ADR, c, d0, d1, n, k);
    `CHK(k, 1'b0)
  endtask
  task automatic rreg(input logic [7:0] c, e0, e1);
    logic [7:0] a;
    logic [7:0] b;
    logic       k;
    wreg(c, 8'h00, 8'h00, 1); // Select before reading
    i_ioxp_bus_master.rd(ADR, a, b, k);
    `CHK({k, a, b}, {1'b0, e0, e1})
  endtask
  initial begin
    repeat (60000) @(posedge core_clk);
    bad_count++;
    stop_test();
  end
  initial begin
    logic [7:0] a;
    logic [7:0] b;
    logic       k;
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (6) @(negedge core_clk);
    `CHK({p0_oe, p1_oe, p0_out, p1_out}, 32'h0000FFFF)
    rreg(8'h02, 8'hFF, 8'hFF);
    rreg(8'h04, 8'h00, 8'h00);
    rreg(8'h06, 8'hFF, 8'hFF);
    for (int s = 0; s < 8; s++) begin
      strap = s[2:0];
      i_ioxp_bus_master.wr({4'h4, s[2:0]}, 8'h02, 8'h00, 8'h00, 1, k);
      `CHK(k, 1'b0)
      i_ioxp_bus_master.wr({4'h4, s[2:1], ~s[0]}, 8'h02, 8'h00, 8'h00, 1, k);
      `CHK(k, 1'b1)
    end
    strap = 3'h5;
    wreg(8'h06, 8'h0F, 8'h3C, 3);
    `CHK({p0_oe, p1_oe}, 16'hF0C3)
    wreg(8'h02, 8'hA5, 8'h5A, 3);
    `CHK({p0_out, p1_out}, 16'hA55A)
    rreg(8'h02, 8'hA5, 8'h5A);
    rreg(8'h00, 8'hA0, 8'h7E);
    wreg(8'h04, 8'hFF, 8'h0F, 3);
    rreg(8'h01, 8'h71, 8'h5F);
    wreg(8'h00, 8'h99, 8'h99, 3);
    rreg(8'hF8, 8'h5F, 8'h71);
    `CHK({p0_out, p0_oe, p1_out, p1_oe}, 32'hA5F05AC3)
    i_ioxp_bus_master.rd(ADR, a, b, k);
    `CHK({k, a, b}, 17'h05F71)
    wreg(8'h03, 8'h66, 8'h00, 2);
    `CHK({p0_out, p1_out}, 16'hA566)
    stop_test();
  end
endmodule
